// >>> pkg/dhp_pkg.sv
package dhp_pkg;
  // --------------------------------------------------------------
  // interface select strap codes
  // --------------------------------------------------------------
  localparam logic [2:0] MODE_ERW_PAR = 3'h1;
  localparam logic [2:0] MODE_RDWR_PAR = 3'h3;
  localparam logic [2:0] MODE_SPI4 = 3'h0;
  localparam logic [2:0] MODE_SPI3 = 3'h4;
  localparam logic [2:0] MODE_I2C = 3'h2;
  // --------------------------------------------------------------
  // bus constants
  // --------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam logic DC_DATA = 1'h1;
  localparam logic DC_CTRL = 1'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    DHP_ACC_RAM_WR,
    DHP_ACC_CMD_WR,
    DHP_ACC_RAM_RD,
    DHP_ACC_STAT_RD
  } dhp_acc_t;
endpackage : dhp_pkg

// >>> pkg/dhp_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dhp_sync_if;
  logic cs_n;
  logic strobe_a;
  logic strobe_b;
  logic dc;
  modport src (output cs_n, output strobe_a, output strobe_b, output dc);
  modport dst (input cs_n, input strobe_a, input strobe_b, input dc);
endinterface : dhp_sync_if
`default_nettype wire

// >>> core/dhp_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dhp_pin_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // raw pins
  input wire logic cs_n_pin,
  input wire logic strobe_a_pin,
  input wire logic strobe_b_pin,
  input wire logic dc_pin,
  // synchronised levels
  dhp_sync_if.src sync
);
  logic [3:0] stage1_reg;
  logic [3:0] stage2_reg;

  // two flops per pin; strobes idle high-safe values after reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1_reg <= 4'h7;
      stage2_reg <= 4'h7;
    end else begin
      stage1_reg <= {dc_pin, strobe_b_pin, strobe_a_pin, cs_n_pin};
      stage2_reg <= stage1_reg;
    end
  end

  assign sync.cs_n = stage2_reg[0];
  assign sync.strobe_a = stage2_reg[1];
  assign sync.strobe_b = stage2_reg[2];
  assign sync.dc = stage2_reg[3];
endmodule : dhp_pin_sync
`default_nettype wire

// >>> core/dhp_parallel_port.sv
// Functional notes
// - straps pick interface: 001 E-RW, 011 RD-WR, 000/100 SPI, 010 I2C.
// - eight-bit data bus driven only during reads, input otherwise.
// - E-RW mode, read_write_select high means ram or status read.
// - E-RW mode, low means write; dc picks ram or command register.
// - E-RW mode, enable high latches data, only with chip select low.
// - first display read after address set is dummy; data follows.
// - RD-WR mode, read strobe low latches read while chip select low.
// - RD-WR read uses dc to choose ram data or status.
// - RD-WR mode, write strobe low latches write while chip select low.
// - RD-WR write uses dc to route byte to ram or command.
// - dc high is display data, dc low is status or command.
// - dummy read needed in RD-WR mode as well.
`timescale 1ns/100ps
`default_nettype none
module dhp_parallel_port #(
  parameter int DW = dhp_pkg::DATA_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // straps and pins
  input wire logic [2:0] interface_select_straps,
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  // data bus
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  // core side: writes
  output logic ram_wr_pulse,
  output logic cmd_wr_pulse,
  output logic [DW-1:0] wr_data,
  // core side: reads
  output logic ram_rd_pulse,
  input wire logic [DW-1:0] ram_rd_data,
  input wire logic [DW-1:0] status_data,
  input wire logic ram_addr_load,
  // mode flags
  output logic mode_erw,
  output logic mode_rdwr,
  output logic mode_serial
);
  // --------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------
  dhp_sync_if sif ();
  logic [DW-1:0] din_s1_reg;
  logic [DW-1:0] din_s2_reg;
  logic [2:0] strap_s1_reg;
  logic [2:0] strap_s2_reg;

  dhp_pin_sync u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cs_n_pin(chip_select_n),
    .strobe_a_pin(read_strobe_n),
    .strobe_b_pin(write_strobe_n),
    .dc_pin(data_command_select),
    .sync(sif.src)
  );

  // data pins and straps also cross in two flops
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
      strap_s1_reg <= 3'h0;
      strap_s2_reg <= 3'h0;
    end else begin
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
      strap_s1_reg <= interface_select_straps;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // --------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------
  wire is_erw = (strap_s2_reg == dhp_pkg::MODE_ERW_PAR);
  wire is_rdwr = (strap_s2_reg == dhp_pkg::MODE_RDWR_PAR);
  wire is_ser = (strap_s2_reg == dhp_pkg::MODE_SPI4) ||
                (strap_s2_reg == dhp_pkg::MODE_SPI3) ||
                (strap_s2_reg == dhp_pkg::MODE_I2C);

  // pins are seen two clocks late, so a host must leave at least one idle
  // clock between windows or back-to-back strobes merge into one
  // in E-RW mode strobe_a is E (active high), strobe_b is R/W
  wire sel_n = sif.cs_n;
  wire erw_act = is_erw && !sel_n && sif.strobe_a;
  wire erw_rd = sif.strobe_b;
  wire rdwr_rd_act = is_rdwr && !sel_n && !sif.strobe_a;
  wire rdwr_wr_act = is_rdwr && !sel_n && !sif.strobe_b;

  wire acc_active = erw_act || rdwr_rd_act || rdwr_wr_act;
  wire acc_is_rd = is_erw ? erw_rd : rdwr_rd_act;

  // --------------------------------------------------------------
  // access state machine
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    DHP_IDLE,
    DHP_READ,
    DHP_WRITE
  } dhp_state_t;

  dhp_state_t state_reg;
  dhp_state_t state_next;
  logic prev_active_reg;
  logic primed_reg;
  logic [DW-1:0] pipe_reg;
  logic [DW-1:0] dout_reg;
  logic [DW-1:0] wdata_reg;
  logic ram_wr_reg;
  logic cmd_wr_reg;
  logic ram_rd_reg;

  // start on the rising edge of the active window and commit writes on its falling edge, so one strobe
  // yields one update however long the host holds it
  wire acc_start = acc_active && !prev_active_reg;
  wire acc_end = !acc_active && prev_active_reg;
  wire dc_data = (sif.dc == dhp_pkg::DC_DATA);

  function automatic dhp_pkg::dhp_acc_t classify(input logic rd,
                                                 input logic dc);
    if (rd && dc) begin
      return dhp_pkg::DHP_ACC_RAM_RD;
    end else if (rd) begin
      return dhp_pkg::DHP_ACC_STAT_RD;
    end else if (dc) begin
      return dhp_pkg::DHP_ACC_RAM_WR;
    end else begin
      return dhp_pkg::DHP_ACC_CMD_WR;
    end
  endfunction : classify

  wire dhp_pkg::dhp_acc_t acc_kind = classify(acc_is_rd, dc_data);
  wire start_rd = acc_start && acc_is_rd;
  wire start_wr = acc_start && !acc_is_rd;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DHP_IDLE: begin
        if (start_rd) begin
          state_next = DHP_READ;
        end else if (start_wr) begin
          state_next = DHP_WRITE;
        end
      end
      DHP_READ: begin
        if (acc_end) begin
          state_next = DHP_IDLE;
        end
      end
      DHP_WRITE: begin
        if (acc_end) begin
          state_next = DHP_IDLE;
        end
      end
      default: begin
        state_next = DHP_IDLE;
      end
    endcase
  end

  // write data is taken when the strobe window closes, the point where
  // the host's data is settled; this costs two cycles of extra latency
  wire wr_commit = (state_reg == DHP_WRITE) && acc_end;
  wire ram_rd_now = start_rd && (acc_kind == dhp_pkg::DHP_ACC_RAM_RD);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= DHP_IDLE;
      prev_active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      prev_active_reg <= acc_active;
    end
  end

  // --------------------------------------------------------------
  // writes
  // --------------------------------------------------------------
  logic wr_dc_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_dc_reg <= dhp_pkg::DC_CTRL;
      wdata_reg <= dhp_pkg::BYTE_ZERO;
      ram_wr_reg <= 1'b0;
      cmd_wr_reg <= 1'b0;
    end else begin
      if (start_wr) begin
        wr_dc_reg <= dc_data;
      end
      if (state_reg == DHP_WRITE) begin
        wdata_reg <= din_s2_reg;
      end
      ram_wr_reg <= wr_commit && wr_dc_reg;
      cmd_wr_reg <= wr_commit && !wr_dc_reg;
    end
  end

  // --------------------------------------------------------------
  // reads with dummy pipeline stage
  // --------------------------------------------------------------
  // each ram read returns the byte fetched by the previous one; after an
  // address load the pipe is empty so the first read is the dummy
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      primed_reg <= 1'b0;
      pipe_reg <= dhp_pkg::BYTE_ZERO;
      dout_reg <= dhp_pkg::BYTE_ZERO;
      ram_rd_reg <= 1'b0;
    end else begin
      ram_rd_reg <= ram_rd_now;
      // an address load beats a fetch in flight: its byte is stale
      if (ram_addr_load) begin
        primed_reg <= 1'b0;
      end else if (ram_rd_reg) begin
        primed_reg <= 1'b1;
      end
      if (ram_rd_reg) begin
        pipe_reg <= ram_rd_data;
      end
      if (start_rd && dc_data) begin
        dout_reg <= primed_reg ? pipe_reg : dhp_pkg::BYTE_ZERO;
      end else if (start_rd) begin
        dout_reg <= status_data;
      end
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign data_out = dout_reg;
  assign data_oe = (state_reg == DHP_READ) && acc_active;
  assign ram_wr_pulse = ram_wr_reg;
  assign cmd_wr_pulse = cmd_wr_reg;
  assign wr_data = wdata_reg;
  assign ram_rd_pulse = ram_rd_reg;
  assign mode_erw = is_erw;
  assign mode_rdwr = is_rdwr;
  assign mode_serial = is_ser;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_oe_only_read: assert property (data_oe |-> state_reg == DHP_READ)
    else $error("bus driven outside a read");
  a_oe_needs_cs: assert property (data_oe |-> !sif.cs_n)
    else $error("bus driven without chip select");
  a_wr_one_pulse: assert property ((ram_wr_pulse || cmd_wr_pulse) |=>
      !(ram_wr_pulse || cmd_wr_pulse))
    else $error("write pulse repeated");
  a_wr_exclusive: assert property (!(ram_wr_pulse && cmd_wr_pulse))
    else $error("ram and command write together");
  a_wr_follows_end: assert property ((ram_wr_pulse || cmd_wr_pulse) |->
      $past(wr_commit))
    else $error("write pulse without strobe end");
  a_ram_route: assert property (wr_commit && wr_dc_reg |=> ram_wr_pulse)
    else $error("data write not routed to ram");
  a_cmd_route: assert property (wr_commit && !wr_dc_reg |=> cmd_wr_pulse)
    else $error("command write not routed");
  a_erw_read: assert property (is_erw && start_rd |-> sif.strobe_b)
    else $error("read started with rw low");
  a_rdwr_read: assert property (is_rdwr && start_rd |-> !sif.strobe_a)
    else $error("read started without read strobe");
  a_dummy_read: assert property (start_rd && dc_data && !primed_reg |=>
      dout_reg == dhp_pkg::BYTE_ZERO)
    else $error("dummy read returned data");
  a_status_read: assert property (start_rd && !dc_data |=>
      dout_reg == $past(status_data))
    else $error("status not returned");
  a_serial_quiet: assert property (is_ser |-> !acc_active)
    else $error("parallel access in serial mode");
  a_rdwr_dummy: assert property (is_rdwr && ram_rd_now |=>
      ram_rd_pulse ##1 (primed_reg || $past(ram_addr_load)))
    else $error("data read did not arm the pipe");
  a_rd_fetch: assert property (start_rd && dc_data |=>
      ram_rd_pulse ##1 !ram_rd_pulse)
    else $error("ram fetch missing or repeated");
  a_wdata_hold: assert property ((ram_wr_pulse || cmd_wr_pulse) |->
      wr_data == $past(din_s2_reg))
    else $error("write data not the last bus byte");
  a_write_state: assert property (start_wr |=> state_reg == DHP_WRITE)
    else $error("write start not tracked");
  a_oe_mode: assert property (data_oe |-> is_erw || is_rdwr)
    else $error("bus driven outside parallel mode");
  a_cs_blocks: assert property (sel_n |-> !acc_active)
    else $error("access without chip select");

  c_ram_write: cover property (ram_wr_pulse);
  c_cmd_write: cover property (cmd_wr_pulse);
  c_primed_read: cover property (start_rd && dc_data && primed_reg);
  c_status_read: cover property (start_rd && !dc_data);
  c_dummy_read: cover property (start_rd && dc_data && !primed_reg);
endmodule : dhp_parallel_port
`default_nettype wire

// >>> verif/dhp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dhp_host_model (
  // clock and mode
  input wire logic sys_clk,
  input wire logic erw_mode,
  // pins
  output logic cs_n,
  output logic dc,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] bus_out,
  output logic bus_oe,
  input wire logic [7:0] bus_in
);
  // --------------------------------------------------------------
  // idle levels
  // --------------------------------------------------------------
  // released bus shows the inverse of the last byte, never a tidy value
  task automatic idle();
    cs_n = 1'h1;
    rd_n = ~erw_mode;
    wr_n = 1'h1;
    bus_oe = 1'h0;
    bus_out = ~bus_out;
  endtask : idle

  initial begin
    dc = 1'h1;
    bus_out = 8'h00;
    idle();
  end

  // --------------------------------------------------------------
  // one access
  // --------------------------------------------------------------
  task automatic access(input logic rd, input logic a0, input logic sel,
                        input logic [7:0] wd, output logic [7:0] rv);
    @(negedge sys_clk);
    cs_n = ~sel;
    dc = a0;
    if (erw_mode) wr_n = rd;
    bus_oe = ~rd;
    bus_out = wd;
    @(negedge sys_clk);
    if (erw_mode) rd_n = 1'h1;
    else if (rd) rd_n = 1'h0;
    else wr_n = 1'h0;
    repeat (6) @(negedge sys_clk);
    @(posedge sys_clk);
    rv = bus_in;
    @(negedge sys_clk);
    rd_n = ~erw_mode;
    wr_n = 1'h1;
    // data held past the strobe because the pins are sampled late
    repeat (3) @(negedge sys_clk);
    idle();
    repeat (6) @(negedge sys_clk);
  endtask : access
endmodule : dhp_host_model
`default_nettype wire

// >>> verif/tb_display_host_parallel_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_display_host_parallel_port;
  logic sys_clk, sys_rst, erw, addr_load;
  logic [2:0] straps;
  logic cs_n, dc, rd_n, wr_n, h_oe, d_oe, ram_wr, cmd_wr, ram_rd;
  logic m_erw, m_rdwr, m_ser;
  logic [7:0] h_out, d_out, wdat, bus, rv, ram_q, stat, last_wr;
  int fail_count = 0;
  int check_count = 0;
  int n_ram = 0;
  int n_cmd = 0;
  int n_rd = 0;
  int n_clash = 0;
  int n_oe = 0;

  assign bus = d_oe ? d_out : h_out;
  assign ram_q = 8'ha0 + n_rd[7:0];

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  dhp_host_model host_i (.sys_clk(sys_clk), .erw_mode(erw), .cs_n(cs_n),
    .dc(dc), .rd_n(rd_n), .wr_n(wr_n), .bus_out(h_out), .bus_oe(h_oe),
    .bus_in(bus));

  dhp_parallel_port dhp_parallel_port_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .interface_select_straps(straps),
    .chip_select_n(cs_n), .data_command_select(dc),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(bus),
    .data_out(d_out), .data_oe(d_oe), .ram_wr_pulse(ram_wr),
    .cmd_wr_pulse(cmd_wr), .wr_data(wdat), .ram_rd_pulse(ram_rd),
    .ram_rd_data(ram_q), .status_data(stat), .ram_addr_load(addr_load),
    .mode_erw(m_erw), .mode_rdwr(m_rdwr), .mode_serial(m_ser));

  always @(posedge sys_clk) begin
    if (ram_wr === 1'h1) n_ram <= n_ram + 1;
    if (cmd_wr === 1'h1) n_cmd <= n_cmd + 1;
    if ((ram_wr | cmd_wr) === 1'h1) last_wr <= wdat;
    if (ram_rd === 1'h1) n_rd <= n_rd + 1;
    if (d_oe === 1'h1) n_oe <= n_oe + 1;
    if ((d_oe & h_oe) !== 1'h0) n_clash <= n_clash + 1;
  end

  // --------------------------------------------------------------
  // compares and helpers
  // --------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_cnt(input int got, input int exp);
    chk_byte(got[7:0], exp[7:0]);
  endtask : chk_cnt

  task automatic wr_chk(input logic a0, input logic sel,
                        input logic [7:0] wd);
    int r0, c0;
    r0 = n_ram;
    c0 = n_cmd;
    host_i.access(1'h0, a0, sel, wd, rv);
    chk_cnt(n_ram - r0, int'(a0 & sel));
    chk_cnt(n_cmd - c0, int'(~a0 & sel));
    if (sel) chk_byte(last_wr, wd);
  endtask : wr_chk

  task automatic rd_chk(input logic a0, input logic [7:0] exp);
    int f0, o0;
    f0 = n_rd;
    o0 = n_oe;
    host_i.access(1'h1, a0, 1'h1, 8'h00, rv);
    chk_byte(rv, exp);
    chk_cnt(n_rd - f0, int'(a0));
    chk_cnt(int'(n_oe > o0), 1);
  endtask : rd_chk

  task automatic set_mode(input logic [2:0] code);
    @(negedge sys_clk);
    straps = code;
    erw = (code == dhp_pkg::MODE_ERW_PAR);
    @(negedge sys_clk);
    host_i.idle();
    repeat (6) @(negedge sys_clk);
  endtask : set_mode

  // reads after an address load: dummy first, then the pipeline
  task automatic rd_seq();
    logic [7:0] b;
    @(negedge sys_clk);
    addr_load = 1'h1;
    @(negedge sys_clk);
    addr_load = 1'h0;
    b = 8'ha0 + n_rd[7:0];
    rd_chk(1'h1, 8'h00);
    rd_chk(1'h1, b);
    rd_chk(1'h0, stat);
    rd_chk(1'h1, b + 8'h01);
  endtask : rd_seq

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_modes();
    logic [2:0] codes [5];
    logic [7:0] e;
    codes = '{dhp_pkg::MODE_ERW_PAR, dhp_pkg::MODE_RDWR_PAR,
              dhp_pkg::MODE_SPI4, dhp_pkg::MODE_SPI3, dhp_pkg::MODE_I2C};
    foreach (codes[i]) begin
      set_mode(codes[i]);
      e = {5'h0, i == 0, i == 1, i > 1};
      chk_byte({5'h0, m_erw, m_rdwr, m_ser}, e);
    end
    $display("t_modes done");
  endtask : t_modes

  task automatic t_rdwr();
    set_mode(dhp_pkg::MODE_RDWR_PAR);
    wr_chk(1'h1, 1'h1, 8'h3c);
    wr_chk(1'h0, 1'h1, 8'hc3);
    wr_chk(1'h1, 1'h0, 8'h81);
    rd_seq();
    $display("t_rdwr done");
  endtask : t_rdwr

  task automatic t_erw();
    set_mode(dhp_pkg::MODE_ERW_PAR);
    wr_chk(1'h0, 1'h1, 8'h5a);
    wr_chk(1'h1, 1'h1, 8'ha5);
    wr_chk(1'h0, 1'h0, 8'h7e);
    rd_seq();
    $display("t_erw done");
  endtask : t_erw

  task automatic t_serial();
    int r0, c0, f0, o0;
    set_mode(dhp_pkg::MODE_SPI4);
    wr_chk(1'h1, 1'h0, 8'h99);
    r0 = n_ram;
    c0 = n_cmd;
    host_i.access(1'h0, 1'h1, 1'h1, 8'h99, rv);
    chk_cnt(n_ram - r0, 0);
    host_i.access(1'h0, 1'h0, 1'h1, 8'h66, rv);
    chk_cnt(n_cmd - c0, 0);
    f0 = n_rd;
    o0 = n_oe;
    host_i.access(1'h1, 1'h1, 1'h1, 8'h00, rv);
    chk_cnt(n_rd - f0, 0);
    chk_cnt(n_oe - o0, 0);
    chk_cnt(n_clash, 0);
    $display("t_serial done");
  endtask : t_serial

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'h1;
    straps = 3'h0;
    erw = 1'h0;
    addr_load = 1'h0;
    stat = 8'h5c;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'h0;
    t_modes();
    t_rdwr();
    t_erw();
    t_serial();
    report_and_stop();
  end
endmodule : tb_display_host_parallel_port
`default_nettype wire
